// File: design/etxc_defs.vh
// constants for the ethernet transmit control and dma busy block
`ifndef ETXC_DEFS_VH
`define ETXC_DEFS_VH
`define ETXC_CLK_MHZ 50
`define ETXC_RST_GAP_NS 1600
`define ETXC_RST_GAP_CYC ((`ETXC_RST_GAP_NS * `ETXC_CLK_MHZ + 999) / 1000)
`define ETXC_CNT_W 8
`define ETXC_DATA_W 8
`define ETXC_FIFO_DEPTH 16
`define ETXC_FIFO_AW 4
`define ETXC_DMA_LEN_W 13
`define ETXC_CTL_TX_REQ 3
`define ETXC_CTL_DMA_BUSY 5
`define ETXC_CTL_TX_RST 7
`define ETXC_FLG_TX_ERR 1
`define ETXC_FLG_TX_DONE 3
`define ETXC_ST_IDLE 3'h1
`define ETXC_ST_SEND 3'h2
`define ETXC_ST_HOLD 3'h4
`endif

// File: design/etxc_fifo.v
// parameterised valid/ready fifo for transmit frame bytes
`timescale 1ns/1ps
module etxc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire flush_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready_o = (cnt_q != DEPTH);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  // storage has no reset; only the pointers and the fill count need a defined value
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end
  // pointers and fill count; flush drops everything queued
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (flush_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// File: design/etxc_top.v
// transmit start, reset, completion control and dma busy tracking
`timescale 1ns/1ps
`include "etxc_defs.vh"
//////////////////////////////////////////////////////////////////////////////
module etxc_top (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire transmit_request_set_i,
  input wire transmit_request_clr_i,
  input wire transmit_logic_reset_i,
  input wire done_flag_clr_i,
  input wire error_flag_clr_i,
  input wire half_duplex_i,
  input wire tx_in_valid_i,
  output reg tx_in_ready_o,
  input wire [`ETXC_DATA_W-1:0] tx_in_data_i,
  input wire tx_in_last_i,
  output reg phy_tx_en_o,
  output reg [`ETXC_DATA_W-1:0] phy_tx_data_o,
  input wire phy_collision_i,
  input wire phy_abort_i,
  input wire dma_start_i,
  input wire [`ETXC_DMA_LEN_W-1:0] dma_len_i,
  input wire rx_frame_event_i,
  output reg transmit_request_o,
  output reg transmit_done_flag_o,
  output reg transmit_error_flag_o,
  output reg dma_busy_o,
  output reg dma_done_o,
  output reg reset_gap_busy_o
);
  // gap length is worked out in integer arithmetic, then cut to the counter width on purpose
  localparam integer GAP_CYC_INT = `ETXC_RST_GAP_CYC;
  localparam [`ETXC_CNT_W-1:0] GAP_CYC = GAP_CYC_INT[`ETXC_CNT_W-1:0];
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [`ETXC_CNT_W-1:0] gap_q;
  reg [`ETXC_DMA_LEN_W-1:0] dma_cnt_q;
  reg last_q;
  wire f_ready;
  wire f_valid;
  wire f_last;
  wire [`ETXC_DATA_W-1:0] f_data;
  wire [`ETXC_DATA_W:0] f_word;
  wire send_pop;
  wire tx_end_ok;
  wire tx_end_err;
  //////////////////////////////////////////////////////////////////////////////
  // one-hot state decode, shared by the pop, abort, close and reset paths
  function etxc_in_state;
    input [2:0] current;
    input [2:0] wanted;
    begin
      etxc_in_state = |(current & wanted);
    end
  endfunction
  // reset gap over; shared by the start test and the gap countdown
  function etxc_gap_over;
    input [`ETXC_CNT_W-1:0] count;
    begin
      etxc_gap_over = (count == {`ETXC_CNT_W{1'b0}});
    end
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // frame bytes plus end marker travel through the fifo; reset flushes it
  etxc_fifo #(
    .WIDTH(`ETXC_DATA_W + 1),
    .DEPTH(`ETXC_FIFO_DEPTH),
    .AW(`ETXC_FIFO_AW)
  ) u_fifo (
    .clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .flush_i(transmit_logic_reset_i),
    .in_valid_i(tx_in_valid_i),
    .in_ready_o(f_ready),
    .in_data_i({tx_in_last_i, tx_in_data_i}),
    .out_valid_o(f_valid),
    .out_ready_i(send_pop),
    .out_data_o(f_word)
  );
  // split the fifo word back into the end marker and the byte
  assign f_last = f_word[`ETXC_DATA_W];
  assign f_data = f_word[`ETXC_DATA_W-1:0];
  // no pop once the end marker left, so the next frame's bytes wait their turn
  assign send_pop = etxc_in_state(state_q, `ETXC_ST_SEND) & f_valid & ~last_q;
  // abort only counts in half duplex; a reset mid-frame is handled separately
  assign tx_end_err = etxc_in_state(state_q, `ETXC_ST_SEND) & half_duplex_i & phy_abort_i;
  assign tx_end_ok = etxc_in_state(state_q, `ETXC_ST_HOLD);
  //////////////////////////////////////////////////////////////////////////////
  // sequencer: idle waits for request, send streams, hold closes the frame
  always @* begin
    state_d = state_q;
    case (state_q)
      `ETXC_ST_IDLE: begin
        if (transmit_request_o & etxc_gap_over(gap_q)) begin
          state_d = `ETXC_ST_SEND;
        end
      end
      `ETXC_ST_SEND: begin
        if (tx_end_err | ~transmit_request_o) begin
          state_d = `ETXC_ST_IDLE;
        end else if (send_pop & f_last) begin
          state_d = `ETXC_ST_HOLD;
        end
      end
      `ETXC_ST_HOLD: begin
        state_d = `ETXC_ST_IDLE;
      end
      default: begin
        state_d = `ETXC_ST_IDLE;
      end
    endcase
  end
  //////////////////////////////////////////////////////////////////////////////
  // transmit control state; reset touches nothing on the receive or dma side
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= `ETXC_ST_IDLE;
      gap_q <= {`ETXC_CNT_W{1'b0}};
      last_q <= 1'b0;
      transmit_request_o <= 1'b0;
      transmit_done_flag_o <= 1'b0;
      transmit_error_flag_o <= 1'b0;
      phy_tx_en_o <= 1'b0;
      phy_tx_data_o <= {`ETXC_DATA_W{1'b0}};
      tx_in_ready_o <= 1'b0;
      reset_gap_busy_o <= 1'b0;
    end else begin
      // ready is a cycle late; a writer pacing a nearly full fifo by it loses bytes
      tx_in_ready_o <= f_ready;
      if (transmit_logic_reset_i) begin
        state_q <= `ETXC_ST_IDLE;
        transmit_request_o <= 1'b0;
        gap_q <= GAP_CYC;
        last_q <= 1'b0;
        phy_tx_en_o <= 1'b0;
        reset_gap_busy_o <= 1'b1;
        // an in-flight frame killed by reset reports as error
        if (!etxc_in_state(state_q, `ETXC_ST_IDLE)) begin
          transmit_error_flag_o <= 1'b1;
        end else if (error_flag_clr_i) begin
          transmit_error_flag_o <= 1'b0;
        end
        if (done_flag_clr_i) begin
          transmit_done_flag_o <= 1'b0;
        end
      end else begin
        state_q <= state_d;
        if (!etxc_gap_over(gap_q)) begin
          gap_q <= gap_q - {{(`ETXC_CNT_W-1){1'b0}}, 1'b1};
        end
        reset_gap_busy_o <= (gap_q > {{(`ETXC_CNT_W-1){1'b0}}, 1'b1});
        // request: end of frame clears it, whether good or abandoned
        if (tx_end_ok | tx_end_err) begin
          transmit_request_o <= 1'b0;
        end else if (transmit_request_set_i) begin
          transmit_request_o <= 1'b1;
        end else if (transmit_request_clr_i) begin
          transmit_request_o <= 1'b0;
        end
        // flags: a set in the clear cycle wins
        if (tx_end_ok) begin
          transmit_done_flag_o <= 1'b1;
        end else if (done_flag_clr_i) begin
          transmit_done_flag_o <= 1'b0;
        end
        if (tx_end_err) begin
          transmit_error_flag_o <= 1'b1;
        end else if (error_flag_clr_i) begin
          transmit_error_flag_o <= 1'b0;
        end
        // phy drive; collisions are ignored here, abort drops drive
        if (send_pop & ~tx_end_err) begin
          phy_tx_en_o <= 1'b1;
          phy_tx_data_o <= f_data;
          last_q <= f_last;
        end else if (state_d != `ETXC_ST_SEND) begin
          phy_tx_en_o <= 1'b0;
          last_q <= 1'b0;
        end
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // dma copy engine busy tracking; receive events cannot stall it
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dma_busy_o <= 1'b0;
      dma_done_o <= 1'b0;
      dma_cnt_q <= {`ETXC_DMA_LEN_W{1'b0}};
    end else begin
      // done is a one-cycle pulse, raised only in the cycle the count runs out
      dma_done_o <= 1'b0;
      if (dma_busy_o) begin
        if (dma_cnt_q == {`ETXC_DMA_LEN_W{1'b0}}) begin
          dma_busy_o <= 1'b0;
          dma_done_o <= 1'b1;
        end else begin
          dma_cnt_q <= dma_cnt_q - {{(`ETXC_DMA_LEN_W-1){1'b0}}, 1'b1};
        end
      end else if (dma_start_i) begin
        dma_busy_o <= 1'b1;
        dma_cnt_q <= dma_len_i;
      end
    end
  end
endmodule

// File: dv/etxc_phy_model.sv
// phy and medium model: collects driven bytes, abandons a frame on command
`timescale 1ns/1ps
module etxc_phy_model (
  input wire clk_i,
  input wire tx_en_i,
  input wire [7:0] tx_data_i,
  input wire abort_cmd_i,
  output reg collision_o = 1'b0,
  output reg abort_o = 1'b0
);
  reg [7:0] rx_q[$];
  // a collision is only reported together with a commanded abort, never by chance
  always @(posedge clk_i) begin
    if (tx_en_i) rx_q.push_back(tx_data_i);
    collision_o <= abort_cmd_i && tx_en_i;
    abort_o <= abort_cmd_i && tx_en_i;
  end
endmodule

// File: dv/etxc_chk.sv
// concurrent checks on the transmit control and dma ports
`timescale 1ns/1ps
module etxc_chk (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire transmit_request_set_i,
  input wire transmit_request_clr_i,
  input wire transmit_logic_reset_i,
  input wire half_duplex_i,
  input wire phy_abort_i,
  input wire dma_start_i,
  input wire phy_tx_en_o,
  input wire transmit_request_o,
  input wire transmit_done_flag_o,
  input wire transmit_error_flag_o,
  input wire dma_busy_o,
  input wire dma_done_o,
  input wire reset_gap_busy_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  reg [7:0] gap_q;
  // gap length counter, restarted by every reset pulse
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) gap_q <= 8'h00;
    else if (transmit_logic_reset_i || !reset_gap_busy_o) gap_q <= 8'h00;
    else gap_q <= gap_q + 8'h01;
  end
  sequence s_req_end;
    $fell(transmit_request_o) && !$past(transmit_request_clr_i) && !$past(transmit_logic_reset_i);
  endsequence
  sequence s_dma_end;
    $fell(dma_busy_o);
  endsequence
  a_req_source: assert property ($rose(transmit_request_o) |-> $past(transmit_request_set_i))
    else $error("request rose without a set pulse");
  a_end_flag: assert property (s_req_end |-> transmit_done_flag_o || transmit_error_flag_o)
    else $error("frame ended with no flag");
  a_abort_stop: assert property (half_duplex_i && phy_abort_i && phy_tx_en_o |-> ##[1:3] !phy_tx_en_o)
    else $error("phy still driven after abort");
  a_gap_len: assert property ($fell(reset_gap_busy_o) |-> gap_q == 8'h50)
    else $error("reset gap length wrong");
  a_gap_hold: assert property (reset_gap_busy_o |-> !$rose(phy_tx_en_o))
    else $error("frame started inside reset gap");
  a_rst_idle: assert property (transmit_logic_reset_i |=> !transmit_request_o)
    else $error("request survived logic reset");
  a_dma_take: assert property (dma_start_i && !dma_busy_o |=> dma_busy_o)
    else $error("dma start not taken");
  a_dma_done: assert property (s_dma_end |-> ##[0:1] dma_done_o)
    else $error("no dma done at end");
  a_done_pulse: assert property (dma_done_o |=> !dma_done_o)
    else $error("dma done longer than one cycle");
endmodule

// File: dv/test_eth_tx_control_recovery.sv
// self-checking bench for transmit control and dma busy
`timescale 1ns/1ps
module test_eth_tx_control_recovery;
  reg ref_clk_i = 0, reset_n_i = 0, transmit_request_set_i = 0, transmit_request_clr_i = 0;
  reg transmit_logic_reset_i = 0, done_flag_clr_i = 0, error_flag_clr_i = 0, half_duplex_i = 1;
  reg tx_in_valid_i = 0, tx_in_last_i = 0, dma_start_i = 0, rx_frame_event_i = 0, abort_cmd = 0;
  reg [7:0] tx_in_data_i = 8'h00;
  reg [12:0] dma_len_i = 13'h0000;
  wire tx_in_ready_o, phy_tx_en_o, phy_collision_i, phy_abort_i, transmit_request_o;
  wire transmit_done_flag_o, transmit_error_flag_o, dma_busy_o, dma_done_o, reset_gap_busy_o;
  wire [7:0] phy_tx_data_o;
  reg [7:0] exp_q[$];
  integer seed = 89989, miscompares = 0, checks_done = 0, i, n, t, k;
  etxc_top i_dut (.*);
  etxc_phy_model i_phy (.clk_i(ref_clk_i), .tx_en_i(phy_tx_en_o), .tx_data_i(phy_tx_data_o),
    .abort_cmd_i(abort_cmd), .collision_o(phy_collision_i), .abort_o(phy_abort_i));
  ////////////////////////////////////////
  // 50 mhz clock
  initial forever #10 ref_clk_i = ~ref_clk_i;
  task chk_v(input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      if (miscompares == 0 && checks_done > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // reset pulse, wait out the gap, then drop any flag the reset raised
  task tx_rst;
    begin
      @(negedge ref_clk_i) transmit_logic_reset_i = 1;
      @(negedge ref_clk_i) transmit_logic_reset_i = 0;
      repeat (82) @(negedge ref_clk_i);
      chk_v(reset_gap_busy_o, 0);
      {done_flag_clr_i, error_flag_clr_i} = 2'h3;
      @(negedge ref_clk_i) {done_flag_clr_i, error_flag_clr_i} = 2'h0;
    end
  endtask
  task load(input integer m);
    for (i = 0; i < m; i = i + 1) begin
      @(negedge ref_clk_i) {tx_in_valid_i, tx_in_last_i} = {1'b1, i == m - 1};
      tx_in_data_i = $random(seed);
      exp_q.push_back(tx_in_data_i);
    end
  endtask
  // request a frame and wait, bounded, for the request to clear
  task send(input integer m, input abt);
    begin
      i_phy.rx_q.delete();
      @(negedge ref_clk_i) {tx_in_valid_i, transmit_request_set_i, abort_cmd} = {2'h1, abt};
      @(negedge ref_clk_i) transmit_request_set_i = 0;
      chk_v(transmit_request_o, 1);
      for (t = 0; transmit_request_o === 1'b1 && t < 200; t = t + 1) @(negedge ref_clk_i);
      abort_cmd = 0;
      chk_v(t < 200, 1);
      chk_v({transmit_done_flag_o, transmit_error_flag_o}, abt ? 1 : 2);
      chk_v(phy_tx_en_o, 0);
      if (!abt) chk_v(i_phy.rx_q.size(), m);
      for (i = 0; !abt && i < m; i = i + 1) chk_v(i_phy.rx_q[i], exp_q[i]);
      exp_q.delete();
    end
  endtask
  // main sequence: shortest, full, random and aborted frames, recovery, dma
  initial begin
    repeat (16) @(negedge ref_clk_i);
    reset_n_i = 1;
    chk_v({transmit_request_o, dma_busy_o, phy_tx_en_o}, 0);
    tx_rst;
    load(1);
    send(1, 0);
    tx_rst;
    load(16);
    @(negedge ref_clk_i) {tx_in_valid_i, tx_in_last_i} = 2'h2;
    @(negedge ref_clk_i) chk_v(tx_in_ready_o, 0);
    send(16, 0);
    for (k = 0; k < 3; k = k + 1) begin
      tx_rst;
      n = 1 + {$random(seed)} % 16;
      load(n);
      send(n, 0);
    end
    tx_rst;
    load(4);
    send(4, 1);
    tx_rst;
    @(negedge ref_clk_i) transmit_request_set_i = 1;
    @(negedge ref_clk_i) transmit_request_set_i = 0;
    repeat (50) @(negedge ref_clk_i);
    chk_v(transmit_request_o, 1);
    transmit_request_clr_i = 1;
    @(negedge ref_clk_i) transmit_request_clr_i = 0;
    @(negedge ref_clk_i) chk_v(transmit_request_o, 0);
    // reset while the sequencer waits in send on an empty fifo reports an error
    @(negedge ref_clk_i) transmit_request_set_i = 1;
    @(negedge ref_clk_i) transmit_request_set_i = 0;
    repeat (3) @(negedge ref_clk_i);
    transmit_logic_reset_i = 1;
    @(negedge ref_clk_i) transmit_logic_reset_i = 0;
    chk_v({transmit_request_o, transmit_error_flag_o, reset_gap_busy_o}, 3);
    tx_rst;
    load(3);
    send(3, 0);
    for (k = 0; k < 4; k = k + 1) begin
      n = k ? 1 + {$random(seed)} % 20 : 1;
      @(negedge ref_clk_i) {dma_len_i, dma_start_i} = {n[12:0], 1'b1};
      @(negedge ref_clk_i) dma_start_i = 0;
      for (t = 0; dma_busy_o === 1'b1 && t < 100; t = t + 1) begin
        dma_start_i = (t == 2);
        rx_frame_event_i = $random(seed);
        @(negedge ref_clk_i);
      end
      dma_start_i = 0;
      chk_v(t, n + 1);
      chk_v(dma_done_o, 1);
    end
    end_sim;
  end
  // hang guard, far beyond the expected run length
  initial begin
    #200000;
    miscompares = miscompares + 1;
    end_sim;
  end
endmodule
bind etxc_top etxc_chk i_chk (.*);
